//--- include/t0a_map.svh
// constants for the t0 apdu transport block
`ifndef T0A_MAP_SVH
`define T0A_MAP_SVH
// ----------------------------------------------------------------------
// procedure and status bytes
// ----------------------------------------------------------------------
`define T0A_PB_MORE      8'h61
`define T0A_PB_WRONG_LEN 8'h6c
`define T0A_SW1_OK       8'h90
`define T0A_SW2_OK       8'h00
`define T0A_SW1_FALLBACK 8'h6f
`define T0A_SW2_FALLBACK 8'h00
// ----------------------------------------------------------------------
// header layout and lengths
// ----------------------------------------------------------------------
`define T0A_HDR_LAST     3'd4
`define T0A_IDX_INS      3'd1
`define T0A_IDX_P1       3'd2
`define T0A_IDX_P2       3'd3
`define T0A_FULL_LEN     9'h100
`endif

//--- include/t0a_pkg.sv
// types for the t0 apdu transport block
package t0a_pkg;
    typedef enum logic [2:0] {
        ST_HDR, ST_APPH, ST_RXD, ST_EXEC, ST_TXD, ST_SW1, ST_SW2
    } t0a_state_e;
    typedef enum logic [1:0] {
        K_C2, K_C3, K_C4
    } t0a_kind_e;
endpackage

//--- src/t0a_transport.sv
// card side t=0 transport exchange engine for apdu cases 2, 3 and 4
// Overview of operation
// [R1] terminal always opens with five-byte header
// [R2] case 2: data then status, or status
// [R3] terminal fills response body and trailer
// [R4] case 3 length byte equals Lc, 1..255
// [R5] terminal sends data under procedure byte control
// [R6] case 3: status after data and execution
// [R7] terminal strips Le from case 4 body
// [R8] case 4: 61xx, or non-9000 status
// [R9] terminal get response length within xx
// [R10] terminal retrieves warning data with Le 00
// [R11] get response handled as case 2
// [R12] 61xx/6Cxx only for cases 2 and 4
// [R13] terminal resends header after 6Cxx
// [R14] error status may replace procedure bytes
// [R15] Le too long: 6C plus available length
// [R16] Le matches: Le bytes then status
// [R17] Le short: Le bytes then 61xx
// [R18] 9000 completes; 61/6C mean incomplete
// [R19] terminal keeps waiting on 60 byte
`timescale 1ns/100ps
`default_nettype none
`include "t0a_map.svh"

module t0a_transport
    import t0a_pkg::*;
(
    // clock and reset
    input  wire logic       i_clk_sys,
    input  wire logic       i_rst_b,
    // bytes from the character layer
    input  wire logic       i_rx_valid,
    input  wire logic [7:0] i_rx_byte,
    // bytes to the character layer
    output logic            o_tx_valid,
    output logic      [7:0] o_tx_byte,
    input  wire logic       i_tx_ready,
    // header handed to the card application
    output logic            o_hdr_valid,
    output logic      [7:0] o_ins,
    output logic      [7:0] o_p1,
    output logic      [7:0] o_p2,
    output logic      [7:0] o_p3,
    // verdict from the card application
    input  wire logic       i_app_done,
    input  wire logic       i_case_data,
    input  wire logic       i_abnormal,
    input  wire logic [8:0] i_avail_len,
    input  wire logic [7:0] i_sw1,
    input  wire logic [7:0] i_sw2,
    // command data to the application
    output logic            o_cmd_valid,
    output logic      [7:0] o_cmd_byte,
    output logic            o_exec_start,
    // response data from the application
    output logic      [7:0] o_resp_idx,
    input  wire logic [7:0] i_resp_byte,
    output logic            o_done
);
    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    t0a_state_e st_q, st_d;
    t0a_kind_e  kind_q, kind_d;
    logic [2:0] hdr_cnt_q;
    logic [8:0] le_q, le_d;
    logic [8:0] cnt_q, cnt_d;
    logic [7:0] sw1_q, sw1_d, sw2_q, sw2_d;
    logic       tail_more_q, tail_more_d;
    logic       ld_en;
    logic [7:0] ld_byte;
    // ------------------------------------------------------------------
    // decode
    // ------------------------------------------------------------------
    wire        tx_free  = !o_tx_valid || i_tx_ready;
    // p3 of zero asks for the full 256 bytes on an outgoing transfer
    wire  [8:0] le_w     = (o_p3 == 8'h00) ? `T0A_FULL_LEN : {1'b0, o_p3};
    wire        le_long  = le_w > i_avail_len;                      // [R15]
    wire        le_equal = le_w == i_avail_len;                     // [R16]
    wire  [8:0] rest_w   = i_avail_len - le_w;                      // [R17]
    // abnormal completion must never report plain success
    wire        sw_ok    = (i_sw1 == `T0A_SW1_OK) && (i_sw2 == `T0A_SW2_OK);
    wire        sw_fix   = i_abnormal && sw_ok;                     // [R8]
    wire  [7:0] sw1_app  = sw_fix ? `T0A_SW1_FALLBACK : i_sw1;
    wire  [7:0] sw2_app  = sw_fix ? `T0A_SW2_FALLBACK : i_sw2;
    wire        data_end = cnt_q == le_q;
    // ------------------------------------------------------------------
    // exchange sequencer
    // ------------------------------------------------------------------
    // the apph ins byte skips the ready wait: the terminal is silent then
    always_comb begin
        st_d        = st_q;
        kind_d      = kind_q;
        le_d        = le_q;
        cnt_d       = cnt_q;
        sw1_d       = sw1_q;
        sw2_d       = sw2_q;
        tail_more_d = tail_more_q;
        ld_en       = 1'b0;
        ld_byte     = o_ins;
        case (st_q)
            ST_HDR: if (i_rx_valid && hdr_cnt_q == `T0A_HDR_LAST) st_d = ST_APPH; // [R1]
            ST_APPH: begin
                if (i_app_done) begin
                    cnt_d = 9'h000;
                    sw1_d = sw1_app;
                    sw2_d = sw2_app;
                    if (i_case_data) begin
                        kind_d = K_C3;
                        le_d   = {1'b0, o_p3};
                        if (i_abnormal) begin
                            st_d = ST_SW1;                              // [R14]
                        end else begin
                            ld_en = 1'b1;                               // ins: send data
                            st_d  = ST_RXD;
                        end
                    end else begin
                        kind_d = K_C2;                                  // [R11]
                        le_d   = le_w;
                        if (i_abnormal) begin
                            st_d = ST_SW1;                              // [R2]
                        end else if (le_long) begin
                            sw1_d = `T0A_PB_WRONG_LEN;                  // [R15]
                            sw2_d = i_avail_len[7:0];
                            st_d  = ST_SW1;
                        end else begin
                            ld_en       = 1'b1;                         // [R16]
                            tail_more_d = !le_equal;                    // [R17]
                            if (!le_equal) begin
                                sw1_d = `T0A_PB_MORE;
                                sw2_d = rest_w[7:0];
                            end
                            st_d = ST_TXD;
                        end
                    end
                end
            end
            ST_RXD: begin
                if (i_rx_valid) cnt_d = cnt_q + 9'h001;
                if (data_end) st_d = ST_EXEC;
            end
            ST_EXEC: begin
                if (i_app_done) begin
                    sw1_d = sw1_app;                                    // [R6]
                    sw2_d = sw2_app;
                    // a normal verdict here with a response means case 4
                    if (!i_case_data && !i_abnormal) begin
                        kind_d = K_C4;
                        sw1_d  = `T0A_PB_MORE;                          // [R8]
                        sw2_d  = i_avail_len[7:0];
                    end
                    st_d = ST_SW1;
                end
            end
            ST_TXD: begin
                if (data_end) begin
                    st_d = ST_SW1;
                end else if (tx_free) begin
                    ld_en   = 1'b1;
                    ld_byte = i_resp_byte;
                    cnt_d   = cnt_q + 9'h001;
                end
            end
            ST_SW1: begin
                if (tx_free) begin
                    ld_en   = 1'b1;
                    ld_byte = sw1_q;
                    st_d    = ST_SW2;
                end
            end
            ST_SW2: begin
                if (tx_free) begin
                    ld_en   = 1'b1;
                    ld_byte = sw2_q;
                    st_d    = ST_HDR;                           // [R18]
                end
            end
            default: st_d = ST_HDR;
        endcase
    end
    // ------------------------------------------------------------------
    // state registers
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_b) begin
            st_q        <= ST_HDR;
            kind_q      <= K_C2;
            le_q        <= 9'h000;
            cnt_q       <= 9'h000;
            sw1_q       <= 8'h00;
            sw2_q       <= 8'h00;
            tail_more_q <= 1'b0;
        end else begin
            st_q        <= st_d;
            kind_q      <= kind_d;
            le_q        <= le_d;
            cnt_q       <= cnt_d;
            sw1_q       <= sw1_d;
            sw2_q       <= sw2_d;
            tail_more_q <= tail_more_d;
        end
    end
    // ------------------------------------------------------------------
    // header capture
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_b) begin
            hdr_cnt_q   <= 3'd0;
            o_hdr_valid <= 1'b0;
            o_ins       <= 8'h00;
            o_p1        <= 8'h00;
            o_p2        <= 8'h00;
            o_p3        <= 8'h00;
        end else begin
            o_hdr_valid <= st_q == ST_HDR && st_d == ST_APPH;
            if (st_q == ST_HDR && i_rx_valid) begin
                hdr_cnt_q <= (hdr_cnt_q == `T0A_HDR_LAST) ? 3'd0 : hdr_cnt_q + 3'd1;
                if (hdr_cnt_q == `T0A_IDX_INS) o_ins <= i_rx_byte;
                if (hdr_cnt_q == `T0A_IDX_P1)  o_p1  <= i_rx_byte;
                if (hdr_cnt_q == `T0A_IDX_P2)  o_p2  <= i_rx_byte;
                if (hdr_cnt_q == `T0A_HDR_LAST) o_p3 <= i_rx_byte;
            end
        end
    end
    // ------------------------------------------------------------------
    // byte outputs and application strobes
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_b) begin
            o_tx_valid   <= 1'b0;
            o_tx_byte    <= 8'h00;
            o_cmd_valid  <= 1'b0;
            o_cmd_byte   <= 8'h00;
            o_exec_start <= 1'b0;
            o_resp_idx   <= 8'h00;
            o_done       <= 1'b0;
        end else begin
            if (ld_en) begin
                o_tx_valid <= 1'b1;
                o_tx_byte  <= ld_byte;
            end else if (i_tx_ready) begin
                o_tx_valid <= 1'b0;
            end
            o_cmd_valid  <= st_q == ST_RXD && i_rx_valid && !data_end;
            o_cmd_byte   <= i_rx_byte;
            o_exec_start <= st_q == ST_RXD && data_end;
            o_resp_idx   <= cnt_d[7:0];
            o_done       <= st_q == ST_SW2 && tx_free;
        end
    end
    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_b);
    wire sw1_out = st_q == ST_SW1 && tx_free;
    sequence s_status_out;
        sw1_out ##1 o_tx_valid;
    endsequence
    chk_proc_case_only: assert property (                        // [R12]
        sw1_out && (sw1_q == `T0A_PB_MORE || sw1_q == `T0A_PB_WRONG_LEN)
        |-> kind_q != K_C3)
        else $error("procedure byte used in case 3");
    chk_abnormal_not_ok: assert property (                       // [R8]
        i_app_done && i_abnormal && (st_q == ST_APPH || st_q == ST_EXEC)
        |=> !(sw1_q == `T0A_SW1_OK && sw2_q == `T0A_SW2_OK))
        else $error("abnormal end reported success");
    chk_wrong_len_avail: assert property (                       // [R15]
        st_q == ST_APPH && i_app_done && !i_case_data && !i_abnormal && le_long
        |=> sw1_q == `T0A_PB_WRONG_LEN && sw2_q == $past(i_avail_len[7:0]))
        else $error("6c length not the available length");
    chk_data_first_ins: assert property (                        // [R16]
        st_q == ST_APPH && i_app_done && !i_case_data && !i_abnormal && !le_long
        |=> o_tx_valid && o_tx_byte == o_ins && st_q == ST_TXD)
        else $error("data not opened with ins byte");
    chk_short_le_more: assert property (                         // [R17]
        st_q == ST_APPH && i_app_done && !i_case_data && !i_abnormal
        && !le_long && !le_equal |=> sw1_q == `T0A_PB_MORE && tail_more_q)
        else $error("short le did not end in 61");
    chk_case4_more: assert property (                            // [R8]
        st_q == ST_EXEC && i_app_done && !i_case_data && !i_abnormal
        |=> sw1_q == `T0A_PB_MORE && kind_q == K_C4)
        else $error("case 4 normal end without 61");
    chk_case3_status: assert property (                          // [R6]
        st_q == ST_RXD && data_end |=> o_exec_start ##0 st_q == ST_EXEC)
        else $error("status path skipped execution");
    chk_status_pair: assert property (                           // [R2]
        s_status_out |-> o_tx_byte == $past(sw1_q) ##[1:300] o_done)
        else $error("status word not completed");
    chk_data_count: assert property (                            // [R16]
        st_q == ST_TXD && data_end |=> st_q == ST_SW1 && cnt_q == le_q)
        else $error("data count differs from le");
endmodule
`default_nettype wire

//--- verification/t0a_term_model.sv
// terminal-side model: sends header and command bytes, collects card bytes
`timescale 1ns/100ps
`default_nettype none
module t0a_term_model (
    // clock
    input  wire logic       i_clk_sys,
    // card to terminal
    input  wire logic       i_tx_valid,
    input  wire logic [7:0] i_tx_byte,
    output logic            o_tx_ready,
    // terminal to card
    output logic            o_rx_valid,
    output logic      [7:0] o_rx_byte,
    // pacing
    input  wire logic       i_slow
);
    logic [7:0] got[$];

    initial begin
        o_rx_valid = 1'b0;
        o_rx_byte  = 8'h00;
    end

    // slow mode stalls the card every other cycle
    always @(negedge i_clk_sys) begin
        o_tx_ready <= i_slow ? !o_tx_ready : 1'b1;
    end

    // every byte taken from the card is kept for the bench to judge
    always @(posedge i_clk_sys) begin
        if (i_tx_valid && o_tx_ready) begin
            got.push_back(i_tx_byte);
        end
    end

    // back-to-back bytes; idle line shows the inverted last byte, never stale
    task automatic send(input logic [7:0] q[$]);
        foreach (q[k]) begin
            o_rx_valid = 1'b1;
            o_rx_byte  = q[k];
            @(negedge i_clk_sys);
        end
        o_rx_valid = 1'b0;
        o_rx_byte  = ~o_rx_byte;
    endtask
endmodule
`default_nettype wire

//--- verification/testbench.sv
// self-checking bench for the t0 apdu transport engine
`timescale 1ns/100ps
`default_nettype none
module testbench;
    typedef logic [7:0] t0a_bq_t[$];
    localparam logic [7:0] ins_c = 8'hb2;
    // clock, reset and pins
    logic       clk = 1'b0;
    logic       rst_b = 1'b0;
    logic       slow = 1'b0;
    logic       rx_valid, tx_valid, tx_ready, hdr_valid, cmd_valid, exec_start, done;
    logic [7:0] rx_byte, tx_byte, ins, p1, p2, p3, cmd_byte, resp_idx;
    logic       app_done = 1'b0;
    logic       case_data = 1'b0;
    logic       abnormal = 1'b0;
    logic [8:0] avail = 9'h000;
    logic [7:0] sw1 = 8'h00;
    logic [7:0] sw2 = 8'h00;
    wire  logic [7:0] resp_byte;
    int         checks = 0;
    int         n_errors = 0;
    int         ncmd = 0;
    logic [7:0] last_cmd = 8'h00;

    // response store: byte k of the reply is k xor 5a
    assign resp_byte = resp_idx ^ 8'h5a;

    initial begin
        forever #2.5 clk = ~clk;
    end

    always @(negedge clk) begin
        if (cmd_valid) begin
            ncmd++;
            last_cmd = cmd_byte;
        end
    end

    t0a_transport t0a_transport_i (
        .i_clk_sys(clk), .i_rst_b(rst_b), .i_rx_valid(rx_valid), .i_rx_byte(rx_byte),
        .o_tx_valid(tx_valid), .o_tx_byte(tx_byte), .i_tx_ready(tx_ready),
        .o_hdr_valid(hdr_valid), .o_ins(ins), .o_p1(p1), .o_p2(p2), .o_p3(p3),
        .i_app_done(app_done), .i_case_data(case_data), .i_abnormal(abnormal),
        .i_avail_len(avail), .i_sw1(sw1), .i_sw2(sw2), .o_cmd_valid(cmd_valid),
        .o_cmd_byte(cmd_byte), .o_exec_start(exec_start), .o_resp_idx(resp_idx),
        .i_resp_byte(resp_byte), .o_done(done));

    t0a_term_model t0a_term_model_i (
        .i_clk_sys(clk), .i_tx_valid(tx_valid), .i_tx_byte(tx_byte),
        .o_tx_ready(tx_ready), .o_rx_valid(rx_valid), .o_rx_byte(rx_byte), .i_slow(slow));

    // ----------------------------------------------------------------------
    // reporting and shared steps
    // ----------------------------------------------------------------------
    task automatic close_out;
        $display("checks=%0d n_errors=%0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic chk_v(input string nm, input logic [15:0] e, input logic [15:0] g);
        checks++;
        if (g !== e) begin
            n_errors++;
            $display("[ERR] %s exp %h got %h", nm, e, g);
        end
    endtask

    // whole reply judged byte by byte, length first; a short reply reads x
    task automatic chk_q(input t0a_bq_t e);
        chk_v("reply length", 16'(e.size()), 16'(t0a_term_model_i.got.size()));
        foreach (e[k]) chk_v("reply byte", {8'h00, e[k]}, {8'h00, t0a_term_model_i.got[k]});
        t0a_term_model_i.got.delete();
    endtask

    // a wait that ran out ends the run at once
    task automatic guard(input int t);
        if (t >= 600) begin
            n_errors++;
            $display("[ERR] wait limit exp 0 got 1");
            close_out();
        end
    endtask

    task automatic hdr(input logic [7:0] p3v);
        int t;
        t0a_term_model_i.send('{8'h00, ins_c, 8'h11, 8'h22, p3v});
        for (t = 0; t < 600 && !hdr_valid; t++) @(negedge clk);
        guard(t);
        chk_v("header ins p3", {ins_c, p3v}, {ins, p3});
        chk_v("header p1 p2", 16'h1122, {p1, p2});
    endtask

    // application verdict: one done strobe, a cycle after the stage opens
    task automatic verdict(input logic cd, input logic ab, input logic [8:0] av,
                           input logic [15:0] sw);
        @(negedge clk);
        app_done = 1'b1;
        case_data = cd;
        abnormal = ab;
        avail = av;
        {sw1, sw2} = sw;
        @(negedge clk);
        app_done = 1'b0;
    endtask

    // command data goes only after the procedure byte has arrived
    task automatic cmd_data(input int n);
        int t;
        t0a_bq_t d;
        for (t = 0; t < 600 && t0a_term_model_i.got.size() == 0; t++) @(negedge clk);
        guard(t);
        for (t = 0; t < n; t++) d.push_back(8'(8'h30 + t));
        ncmd = 0;
        t0a_term_model_i.send(d);
        for (t = 0; t < 600 && !exec_start; t++) @(negedge clk);
        guard(t);
        chk_v("command count", 16'(n), 16'(ncmd));
        chk_v("last command byte", 16'(8'h30 + n - 1), {8'h00, last_cmd});
    endtask

    task automatic reply(input t0a_bq_t e);
        int t;
        for (t = 0; t < 600 && !done; t++) @(negedge clk);
        guard(t);
        for (t = 0; t < 600 && tx_valid; t++) @(negedge clk);
        guard(t);
        chk_q(e);
    endtask

    function automatic t0a_bq_t body(input int n, input logic [7:0] a, input logic [7:0] b);
        t0a_bq_t q;
        int      k;
        q.push_back(ins_c);
        for (k = 0; k < n; k++) q.push_back(8'(k) ^ 8'h5a);
        q.push_back(a);
        q.push_back(b);
        return q;
    endfunction

    // ----------------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------------
    // case 2, le equal to what is held, 00 meaning a full 256
    task automatic s_c2_exact;
        hdr(8'h03);
        verdict(1'b0, 1'b0, 9'h003, 16'h9000);
        reply(body(3, 8'h90, 8'h00));
        hdr(8'h00);
        verdict(1'b0, 1'b0, 9'h100, 16'h9000);
        reply(body(256, 8'h90, 8'h00));
    endtask

    // case 2 asking too much: 6c, then the header resent with p3 = xx
    task automatic s_c2_long;
        hdr(8'h00);
        verdict(1'b0, 1'b0, 9'h00a, 16'h9000);
        reply('{8'h6c, 8'h0a});
        hdr(8'h0a);
        verdict(1'b0, 1'b0, 9'h00a, 16'h9000);
        reply(body(10, 8'h90, 8'h00));
    endtask

    // case 2 asking less while the terminal stalls, then an abnormal one
    task automatic s_c2_short;
        slow = 1'b1;
        hdr(8'h02);
        verdict(1'b0, 1'b0, 9'h005, 16'h9000);
        reply(body(2, 8'h61, 8'h03));
        slow = 1'b0;
        hdr(8'h04);
        verdict(1'b0, 1'b1, 9'h004, 16'h6a82);
        reply('{8'h6a, 8'h82});
    endtask

    // case 3: status only after data and execution, no 61 or 6c
    task automatic s_c3;
        hdr(8'h02);
        verdict(1'b1, 1'b0, 9'h000, 16'h9000);
        cmd_data(2);
        verdict(1'b1, 1'b0, 9'h000, 16'h9000);
        reply(body(0, 8'h90, 8'h00));
    endtask

    // case 4: 61xx, get response as case 2, abnormal 9000 never passes,
    // a warning end is followed by a get response with le 00
    task automatic s_c4;
        hdr(8'h01);
        verdict(1'b1, 1'b0, 9'h000, 16'h9000);
        cmd_data(1);
        verdict(1'b0, 1'b0, 9'h004, 16'h9000);
        reply(body(0, 8'h61, 8'h04));
        hdr(8'h04);
        verdict(1'b0, 1'b0, 9'h004, 16'h9000);
        reply(body(4, 8'h90, 8'h00));
        hdr(8'h03);
        verdict(1'b1, 1'b0, 9'h000, 16'h9000);
        cmd_data(3);
        verdict(1'b0, 1'b1, 9'h004, 16'h9000);
        reply(body(0, 8'h6f, 8'h00));
        hdr(8'h02);
        verdict(1'b1, 1'b0, 9'h000, 16'h9000);
        cmd_data(2);
        verdict(1'b0, 1'b1, 9'h004, 16'h6282);
        reply(body(0, 8'h62, 8'h82));
        hdr(8'h00);
        verdict(1'b0, 1'b0, 9'h004, 16'h9000);
        reply('{8'h6c, 8'h04});
        hdr(8'h04);
        verdict(1'b0, 1'b0, 9'h004, 16'h9000);
        reply(body(4, 8'h90, 8'h00));
    endtask

    initial begin
        repeat (10) @(negedge clk);
        rst_b = 1'b1;
        s_c2_exact();
        s_c2_long();
        s_c2_short();
        s_c3();
        s_c4();
        close_out();
    end
endmodule
`default_nettype wire
